// *** shared/ccp_cfg.svh ***
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

// Register word addresses
`define ADDR_UNIT_CONTROL    2'h0
`define ADDR_VALUE_LOW_BYTE  2'h1
`define ADDR_VALUE_HIGH_BYTE 2'h2
`define ADDR_UNIT_STATUS     2'h3

// Control register layout
`define CTRL_RESET           8'h00
`define CTRL_WRITE_MASK      8'h3f
`define CTRL_MODE_MSB        3
`define CTRL_MODE_LSB        0
`define CTRL_DUTY_MSB        5
`define CTRL_DUTY_LSB        4

// Status register layout
`define STAT_FLAG_BIT        0

// Value register reset
`define VALUE_RESET          8'h00

// Mode select codes
`define MODE_OFF             4'h0
`define MODE_CMP_TOGGLE      4'h2
`define MODE_CAP_FALL        4'h4
`define MODE_CAP_RISE        4'h5
`define MODE_CAP_RISE4       4'h6
`define MODE_CAP_RISE16      4'h7
`define MODE_CMP_SET         4'h8
`define MODE_CMP_CLEAR       4'h9
`define MODE_CMP_SOFT        4'ha
`define MODE_CMP_SPECIAL     4'hb
`define MODE_PWM_LOW_TRUE    3'h7

// Capture prescaler wrap points (count minus one)
`define PRESCALE_WRAP_4      4'h3
`define PRESCALE_WRAP_16     4'hf

`endif

// *** shared/ccp_pkg.sv ***
package ccp_pkg;

    // Operating class decoded from the mode select field
    typedef enum logic [3:0] {
        unit_off     = 4'b0001,
        unit_capture = 4'b0010,
        unit_compare = 4'b0100,
        unit_pwm     = 4'b1000
    } unit_class_t;

    // Capture edge prescale selection
    typedef enum logic [1:0] {
        ratio_one     = 2'h0,
        ratio_four    = 2'h1,
        ratio_sixteen = 2'h2
    } prescale_ratio_t;

endpackage

// *** shared/pin_edge_if.sv ***
`timescale 1ns/1ps
interface pin_edge_if;
    logic rise;
    logic fall;

    modport drv (output rise, output fall);
    modport rcv (input rise, input fall);
endinterface

// *** test/ccp_assertions.sv ***
`timescale 1ns/1ps
module ccp_assertions (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [1:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        unit_pin_out,
    input wire logic        unit_pin_oe,
    input wire logic        timer_one_tick,
    input wire logic        timer_one_reset,
    input wire logic [7:0]  timer_two_count,
    input wire logic [7:0]  timer_two_period,
    input wire logic        timer_two_tick,
    input wire logic        timer_two_clear,
    input wire logic        adc_enabled,
    input wire logic        special_event_trigger,
    input wire logic        adc_start,
    input wire logic        unit_interrupt_flag
);
    logic [7:0] ctrl_ff;
    logic [3:0] mode;
    logic       flag_clr, cmp_cls, pwm_evt;

    // Shadow of the control register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_ff <= 8'h00;
        end else if (reg_wr && reg_addr == 2'h0) begin
            ctrl_ff <= reg_wdata & 8'h3f;
        end
    end

    // Decoded mode and events
    assign mode     = ctrl_ff[3:0];
    assign flag_clr = reg_wr && reg_addr == 2'h3 && reg_wdata[0];
    assign cmp_cls  = mode == 4'h2 || mode[3:2] == 2'b10;
    assign pwm_evt  = timer_two_tick && timer_two_count == timer_two_period && mode[3:2] == 2'b11;

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    a_adc_start_gate: assert property (adc_start == (special_event_trigger && adc_enabled))
        else $error("adc start mismatch");
    a_trigger_cause: assert property (special_event_trigger |-> mode == 4'hb && $past(timer_one_tick))
        else $error("stray trigger");
    a_trigger_single: assert property (special_event_trigger |=> !special_event_trigger)
        else $error("long trigger");
    a_reset_on_tick: assert property (timer_one_reset |-> timer_one_tick && mode == 4'hb)
        else $error("stray timer reset");
    a_flag_sw_clear: assert property ($fell(unit_interrupt_flag) |-> $past(flag_clr))
        else $error("flag lost");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("stray read data");
    a_oe_by_mode: assert property (unit_pin_oe == (cmp_cls || mode[3:2] == 2'b11))
        else $error("pin enable mismatch");
    a_zero_ctrl_low: assert property (ctrl_ff == 8'h00 |-> !unit_pin_out)
        else $error("pin high when off");
    a_soft_pin_hold: assert property ((mode == 4'ha || mode == 4'hb) && $stable(ctrl_ff) |-> $stable(unit_pin_out))
        else $error("pin moved");
    a_pwm_period_clr: assert property (timer_two_clear == pwm_evt)
        else $error("stray period clear");

    c_special: cover property (special_event_trigger && adc_start);
    c_capture: cover property ($rose(unit_interrupt_flag) && mode[3:2] == 2'b01);
    c_pwm: cover property (pwm_evt);
endmodule

bind capture_compare_pwm_unit ccp_assertions ccp_assertions_i (.*);

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic        core_clk, reset, reg_wr, reg_rd, unit_pin_in, unit_pin_out, unit_pin_oe, run_one, overflow_flag;
    logic        timer_one_tick, timer_one_reset, timer_two_tick, timer_two_clear, adc_enabled, adc_start;
    logic        special_event_trigger, unit_interrupt_flag;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, timer_two_count, timer_two_period;
    logic [15:0] timer_one_count;
    int          n_mismatch = 0, samples_checked = 0;

    capture_compare_pwm_unit capture_compare_pwm_unit_i (.*);
    timer_model timer_model_i (.*);

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Compare and report
    task chk(input string w, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask
    task chk1(input string w, input logic e, input logic g);
        chk(w, 16'(e), 16'(g));
    endtask

    // Register bus cycles
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    // Bounded wait: 0 flag, 1 trigger, 2 timer reset, 3 period event
    task await(input int sel, input int n);
        logic [3:0] s;
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            s = {timer_two_clear, timer_one_reset, special_event_trigger, unit_interrupt_flag};
            if (s[sel] === 1'b1) return;
        end
        n_mismatch++;
        $display("[ERR] wait %0d expected 1 seen 0", sel);
        results();
    endtask

    // Pin edges past the synchroniser
    task pin_to(input logic b);
        @(posedge core_clk);
        unit_pin_in <= b;
        repeat (8) @(posedge core_clk);
    endtask
    task rises(input int n);
        repeat (n) begin
            pin_to(1'b0);
            pin_to(1'b1);
        end
    endtask
    task run_t1();
        @(posedge core_clk);
        run_one <= 1'b1;
        repeat (20) @(posedge core_clk);
        run_one <= 1'b0;
    endtask
    task capchk();
        logic [7:0] lo, hi;
        rd(2'h1, lo);
        rd(2'h2, hi);
        chk("capture", timer_one_count, {hi, lo});
    endtask

    // Match four ticks ahead in the given mode
    task arm(input logic [3:0] m);
        logic [15:0] v;
        v = timer_one_count + 16'h0004;
        wr(2'h1, v[7:0]);
        wr(2'h2, v[15:8]);
        wr(2'h0, {4'h0, m});
        wr(2'h3, 8'h01);
        await(0, 80);
    endtask

    // High cycles over one full PWM period
    task duty(input logic [7:0] lo, input logic [7:0] ctrl, output int h);
        wr(2'h1, lo);
        wr(2'h0, ctrl);
        await(3, 1100);
        await(3, 40);
        h = 0;
        repeat (16) begin
            @(negedge core_clk);
            h += (unit_pin_out === 1'b1);
        end
    endtask

    task s_regs();
        logic [7:0] d;
        rd(2'h0, d);
        chk("control reset", 16'h0000, {8'h00, d});
        wr(2'h0, 8'hff);
        rd(2'h0, d);
        chk("control mask", 16'h003f, {8'h00, d});
        wr(2'h0, 8'h00);
        wr(2'h1, 8'ha5);
        wr(2'h2, 8'h5a);
        rd(2'h1, d);
        chk("low byte", 16'h00a5, {8'h00, d});
        rd(2'h2, d);
        chk("high byte", 16'h005a, {8'h00, d});
    endtask

    task s_compare();
        logic [3:0] m [4];
        logic [3:0] p;
        m = '{4'h8, 4'h9, 4'h2, 4'ha};
        p = 4'b1101;
        for (int k = 0; k < 4; k++) begin
            arm(m[k]);
            chk1("compare pin", p[k], unit_pin_out);
        end
        wr(2'h0, 8'h00);
        @(negedge core_clk);
        chk1("cleared pin", 1'b0, unit_pin_out);
    endtask

    task s_special();
        logic [15:0] v;
        v = timer_one_count + 16'h0004;
        wr(2'h1, v[7:0]);
        adc_enabled <= 1'b1;
        wr(2'h2, v[15:8]);
        wr(2'h0, 8'h0b);
        await(1, 80);
        chk1("adc start", 1'b1, adc_start);
        await(2, 8);
        @(negedge core_clk);
        chk("timer cleared", 16'h0000, timer_one_count);
        chk1("no overflow", 1'b0, overflow_flag);
        v = timer_one_count + 16'h0004;
        wr(2'h1, v[7:0]);
        adc_enabled <= 1'b0;
        wr(2'h2, v[15:8]);
        await(1, 80);
        chk1("adc idle", 1'b0, adc_start);
        wr(2'h1, v[7:0] + 8'h01);
        repeat (3) @(negedge core_clk);
        chk("reset cancelled", v + 16'h0001, timer_one_count);
        wr(2'h0, 8'h00);
    endtask

    task s_capture();
        @(posedge core_clk);
        run_one <= 1'b0;
        wr(2'h0, 8'h04);
        wr(2'h3, 8'h01);
        pin_to(1'b1);
        chk1("rise ignored", 1'b0, unit_interrupt_flag);
        pin_to(1'b0);
        chk1("fall captured", 1'b1, unit_interrupt_flag);
        capchk();
        run_t1();
        wr(2'h0, 8'h05);
        wr(2'h3, 8'h01);
        pin_to(1'b1);
        chk1("rise captured", 1'b1, unit_interrupt_flag);
        capchk();
        run_t1();
        rises(1);
        chk1("flag kept", 1'b1, unit_interrupt_flag);
        capchk();
        wr(2'h0, 8'h00);
        wr(2'h0, 8'h06);
        wr(2'h3, 8'h01);
        rises(2);
        wr(2'h0, 8'h00);
        wr(2'h0, 8'h06);
        rises(3);
        chk1("prescale cleared", 1'b0, unit_interrupt_flag);
        rises(1);
        chk1("fourth rise", 1'b1, unit_interrupt_flag);
        wr(2'h3, 8'h01);
        rises(2);
        wr(2'h0, 8'h07);
        wr(2'h3, 8'h01);
        rises(13);
        chk1("prescale kept", 1'b0, unit_interrupt_flag);
        rises(1);
        chk1("sixteenth rise", 1'b1, unit_interrupt_flag);
        wr(2'h0, 8'h00);
        run_one <= 1'b1;
    endtask

    task s_pwm();
        int         h0, h;
        logic [7:0] d;
        @(posedge core_clk);
        timer_two_period <= 8'h03;
        duty(8'h01, 8'h2c, h0);
        duty(8'h01, 8'h1d, h);
        chk("duty minus one", 16'(h0 - 1), 16'(h));
        duty(8'h02, 8'h2c, h);
        chk("duty plus four", 16'(h0 + 4), 16'(h));
        rd(2'h2, d);
        chk("duty reload", 16'h0002, {8'h00, d});
        wr(2'h2, 8'h77);
        rd(2'h2, d);
        chk("high byte locked", 16'h0002, {8'h00, d});
        duty(8'h01, 8'h2e, h);
        chk("low true", 16'(16 - h0), 16'(h));
        duty(8'h00, 8'h0c, h);
        chk("zero duty", 16'h0000, 16'(h));
        wr(2'h0, 8'h00);
        @(negedge core_clk);
        chk1("pwm cleared", 1'b0, unit_pin_out);
    endtask

    // Verdict and end of run
    task results();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Reset then scenarios
    initial begin
        reset = 1'b1;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        unit_pin_in = 1'b0;
        timer_two_period = 8'hff;
        adc_enabled = 1'b0;
        run_one = 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        s_regs();
        s_compare();
        s_special();
        s_capture();
        s_pwm();
        results();
    end
endmodule

// *** test/timer_model.sv ***
`timescale 1ns/1ps
module timer_model (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        run_one,
    input  wire logic        timer_one_reset,
    input  wire logic        timer_two_clear,
    output logic      [15:0] timer_one_count,
    output logic             timer_one_tick,
    output logic             overflow_flag,
    output logic      [7:0]  timer_two_count,
    output logic             timer_two_tick
);
    logic [1:0]  div_ff;
    logic [15:0] one_ff;
    logic [7:0]  two_ff;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div_ff <= 2'h0;
        end else begin
            div_ff <= div_ff + 2'h1;
        end
    end

    // trigger reset at increment, no overflow
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            one_ff <= 16'h0000;
            overflow_flag <= 1'b0;
        end else if (timer_one_tick) begin
            one_ff <= timer_one_reset ? 16'h0000 : one_ff + 16'h0001;
            overflow_flag <= overflow_flag | (!timer_one_reset && one_ff == 16'hffff);
        end
    end

    // Period clear replaces the increment
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            two_ff <= 8'h00;
        end else if (timer_two_tick) begin
            two_ff <= timer_two_clear ? 8'h00 : two_ff + 8'h01;
        end
    end

    assign timer_one_tick  = run_one && div_ff == 2'h3;
    assign timer_two_tick  = div_ff == 2'h3;
    assign timer_one_count = one_ff;
    assign timer_two_count = two_ff;
endmodule

// *** verilog/capture_compare_pwm_unit.sv ***
`timescale 1ns/1ps
`include "ccp_cfg.svh"
// Functional notes
// - Value is 16 bits, reached as separate low and high byte registers.
// - Mode 0000 turns the unit off and clears prescaler, sub-count, PWM latch and pending reset.
// - Modes 0100-0111 capture on falling, rising, 4th rising, 16th rising edge.
// - Mode 0010 toggles the output on each match and sets the flag.
// - Mode 1000 drives output high, 1001 drives low on match; both set flag.
// - Mode 1010 sets only the flag on match; pin untouched.
// - Mode 1011 sets flag, resets timer one, starts conversion if enabled.
// - Modes 110x give active-high PWM, 111x active-low PWM; bit 0 ignored.
// - PWM duty is low byte (upper eight) plus control duty bits (lower two).
// - A qualifying capture event copies the 16-bit timer one count.
// - Each capture sets the flag; only software clears it.
// - A new capture overwrites an unread value.
// - Prescaler clears when off, in non-capture modes, and on reset.
// - Switching between capture prescales keeps the count; may raise flag.
// - Compare mode matches value against timer one; acts and sets flag.
// - Writing zero to the control register forces the compare latch low.
// - Trigger fires at match; timer one resets at its next increment.
// - A trigger-caused timer one reset does not set its overflow flag.
// - Changing the value so the match fails cancels the pending reset.
// - Writing zero to the control register drives PWM latch inactive.
// - After timer two hits period: clear it, set output unless 0%, reload duty.
// - PWM output clears when buffered duty equals timer two with sub-count.
module capture_compare_pwm_unit
    import ccp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [1:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        unit_pin_in,
    output logic             unit_pin_out,
    output logic             unit_pin_oe,
    input  wire logic [15:0] timer_one_count,
    input  wire logic        timer_one_tick,
    output logic             timer_one_reset,
    input  wire logic [7:0]  timer_two_count,
    input  wire logic [7:0]  timer_two_period,
    input  wire logic        timer_two_tick,
    output logic             timer_two_clear,
    input  wire logic        adc_enabled,
    output logic             special_event_trigger,
    output logic             adc_start,
    output logic             unit_interrupt_flag
);
    // Software-visible registers
    logic [7:0]       control_ff;
    logic [7:0]       value_low_ff;
    logic [7:0]       value_high_ff;
    logic             flag_ff;
    logic [7:0]       rdata_ff;

    // Unit state
    logic             cmp_latch_ff;
    logic             pwm_latch_ff;
    logic [1:0]       duty_latch_ff;
    logic [1:0]       sub_count_ff;
    logic             cmp_eval_ff;
    logic             reset_pending_ff;

    // Decoded control
    logic [3:0]       mode_select;
    logic [1:0]       duty_low_bits;
    unit_class_t      unit_class;
    prescale_ratio_t  ratio;
    logic             capture_step;
    logic             capture_fire;
    logic             capture_evt;
    logic             match_now;
    logic             match_evt;
    logic             period_evt;
    logic             duty_zero;
    logic             duty_hit;
    logic             ctrl_zero_wr;
    logic             low_wr;
    logic             high_wr;
    logic             flag_clr;
    logic [15:0]      value_pair;

    pin_edge_if edges ();

    assign mode_select   = control_ff[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    assign duty_low_bits = control_ff[`CTRL_DUTY_MSB:`CTRL_DUTY_LSB];
    // two byte halves form one value
    assign value_pair    = {value_high_ff, value_low_ff};

    // Decode the operating class
    always_comb begin
        case (mode_select)
            `MODE_CMP_TOGGLE,
            `MODE_CMP_SET,
            `MODE_CMP_CLEAR,
            `MODE_CMP_SOFT,
            `MODE_CMP_SPECIAL: unit_class = unit_compare;
            `MODE_CAP_FALL,
            `MODE_CAP_RISE,
            `MODE_CAP_RISE4,
            `MODE_CAP_RISE16:  unit_class = unit_capture;
            default: begin
                // low code bit ignored for PWM
                if (mode_select[3] && mode_select[2]) begin
                    unit_class = unit_pwm;
                end else begin
                    unit_class = unit_off;
                end
            end
        endcase
    end

    // Edge kind and prescale per capture code
    always_comb begin
        case (mode_select)
            `MODE_CAP_FALL:   capture_step = edges.fall;
            `MODE_CAP_RISE,
            `MODE_CAP_RISE4,
            `MODE_CAP_RISE16: capture_step = edges.rise;
            default:          capture_step = 1'b0;
        endcase
    end

    always_comb begin
        case (mode_select)
            `MODE_CAP_RISE4:  ratio = ratio_four;
            `MODE_CAP_RISE16: ratio = ratio_sixteen;
            default:          ratio = ratio_one;
        endcase
    end

    // pin synchronised, edges from clean level
    pin_edge_sync u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .pin_in   (unit_pin_in),
        .edges    (edges.drv)
    );

    edge_prescaler u_prescale (
        .core_clk (core_clk),
        .reset    (reset),
        .clear    (unit_class != unit_capture),
        .step     (capture_step),
        .ratio    (ratio),
        .fire     (capture_fire)
    );

    assign capture_evt = (unit_class == unit_capture) && capture_fire;

    // Register bus strobes
    assign low_wr       = reg_wr && (reg_addr == `ADDR_VALUE_LOW_BYTE);
    assign high_wr      = reg_wr && (reg_addr == `ADDR_VALUE_HIGH_BYTE) && (unit_class != unit_pwm);
    assign ctrl_zero_wr = reg_wr && (reg_addr == `ADDR_UNIT_CONTROL)
                          && ((reg_wdata & `CTRL_WRITE_MASK) == `CTRL_RESET);
    assign flag_clr     = reg_wr && (reg_addr == `ADDR_UNIT_STATUS) && reg_wdata[`STAT_FLAG_BIT];

    // Control register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            control_ff <= `CTRL_RESET;
        end else if (reg_wr && (reg_addr == `ADDR_UNIT_CONTROL)) begin
            control_ff <= reg_wdata & `CTRL_WRITE_MASK;
        end
    end

    // evaluate one cycle after each timer one increment
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cmp_eval_ff <= 1'b0;
        end else begin
            cmp_eval_ff <= timer_one_tick;
        end
    end

    assign match_now = (timer_one_count == value_pair);
    assign match_evt = (unit_class == unit_compare) && cmp_eval_ff && match_now;

    // Low byte: capture wins over a software write in the same cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            value_low_ff <= `VALUE_RESET;
        end else if (capture_evt) begin
            value_low_ff <= timer_one_count[7:0];
        end else if (low_wr) begin
            value_low_ff <= reg_wdata;
        end
    end

    // High byte: capture, PWM reload, or software write
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            value_high_ff <= `VALUE_RESET;
        end else if (capture_evt) begin
            value_high_ff <= timer_one_count[15:8];
        end else if (period_evt) begin
            value_high_ff <= value_low_ff;
        end else if (high_wr) begin
            value_high_ff <= reg_wdata;
        end
    end

    // Interrupt flag, set beats clear
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            flag_ff <= 1'b0;
        end else if (capture_evt || match_evt) begin
            // match sets flag in every compare code
            flag_ff <= 1'b1;
        end else if (flag_clr) begin
            flag_ff <= 1'b0;
        end
    end

    // Compare output latch
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cmp_latch_ff <= 1'b0;
        end else if (ctrl_zero_wr) begin
            // forced low on zero control write
            cmp_latch_ff <= 1'b0;
        end else if (match_evt) begin
            case (mode_select)
                `MODE_CMP_TOGGLE: cmp_latch_ff <= ~cmp_latch_ff;
                `MODE_CMP_SET:    cmp_latch_ff <= 1'b1;
                `MODE_CMP_CLEAR:  cmp_latch_ff <= 1'b0;
                default:          cmp_latch_ff <= cmp_latch_ff;
            endcase
        end
    end

    // pending timer one reset until its next increment
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reset_pending_ff <= 1'b0;
        end else if (mode_select != `MODE_CMP_SPECIAL) begin
            reset_pending_ff <= 1'b0;
        end else if (match_evt) begin
            reset_pending_ff <= 1'b1;
        end else if (timer_one_tick || !match_now) begin
            reset_pending_ff <= 1'b0;
        end
    end

    assign special_event_trigger = match_evt && (mode_select == `MODE_CMP_SPECIAL);
    assign adc_start             = special_event_trigger && adc_enabled;
    // a clear, never counted as an overflow
    assign timer_one_reset       = reset_pending_ff && timer_one_tick && match_now;

    // period boundary on increment after equality
    assign period_evt      = (unit_class == unit_pwm) && timer_two_tick
                             && (timer_two_count == timer_two_period);
    assign timer_two_clear = period_evt;
    // ten-bit duty from low byte and duty bits
    assign duty_zero       = (value_low_ff == 8'h00) && (duty_low_bits == 2'h0);
    // buffered duty against extended timer two
    assign duty_hit        = {value_high_ff, duty_latch_ff} == {timer_two_count, sub_count_ff};

    // Two low-order sub-count bits between timer two increments
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sub_count_ff <= 2'h0;
        end else if (timer_two_tick || (unit_class != unit_pwm)) begin
            sub_count_ff <= 2'h0;
        end else begin
            sub_count_ff <= sub_count_ff + 2'h1;
        end
    end

    // Duty low-bit latch, second half of the double buffer
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            duty_latch_ff <= 2'h0;
        end else if (period_evt) begin
            duty_latch_ff <= duty_low_bits;
        end
    end

    // PWM output latch
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pwm_latch_ff <= 1'b0;
        end else if (ctrl_zero_wr || (unit_class != unit_pwm)) begin
            pwm_latch_ff <= 1'b0;
        end else if (period_evt) begin
            pwm_latch_ff <= !duty_zero;
        end else if (duty_hit) begin
            pwm_latch_ff <= 1'b0;
        end
    end

    // Pin drive per class
    always_comb begin
        case (unit_class)
            unit_compare: begin
                unit_pin_out = cmp_latch_ff;
                unit_pin_oe  = 1'b1;
            end
            unit_pwm: begin
                if (mode_select[3:1] == `MODE_PWM_LOW_TRUE) begin
                    unit_pin_out = ~pwm_latch_ff;
                end else begin
                    unit_pin_out = pwm_latch_ff;
                end
                unit_pin_oe = 1'b1;
            end
            default: begin
                unit_pin_out = 1'b0;
                unit_pin_oe  = 1'b0;
            end
        endcase
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_UNIT_CONTROL:    rdata_ff <= control_ff;
                `ADDR_VALUE_LOW_BYTE:  rdata_ff <= value_low_ff;
                `ADDR_VALUE_HIGH_BYTE: rdata_ff <= value_high_ff;
                `ADDR_UNIT_STATUS:     rdata_ff <= {7'h00, flag_ff};
                default:               rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata           = rdata_ff;
    assign unit_interrupt_flag = flag_ff;
endmodule

// *** verilog/edge_prescaler.sv ***
`timescale 1ns/1ps
`include "ccp_cfg.svh"
module edge_prescaler
    import ccp_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            reset,
    input  wire logic            clear,
    input  wire logic            step,
    input  prescale_ratio_t      ratio,
    output logic                 fire
);
    logic [3:0] count_ff;
    logic [3:0] wrap;

    // Wrap point for the selected ratio
    always_comb begin
        case (ratio)
            ratio_four:    wrap = `PRESCALE_WRAP_4;
            ratio_sixteen: wrap = `PRESCALE_WRAP_16;
            default:       wrap = 4'h0;
        endcase
    end

    assign fire = step && (count_ff >= wrap);

    // Counts qualifying edges; clear wins over counting
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count_ff <= 4'h0;
        end else if (clear) begin
            count_ff <= 4'h0;
        end else if (fire) begin
            count_ff <= 4'h0;
        end else if (step) begin
            count_ff <= count_ff + 4'h1;
        end
    end
endmodule

// *** verilog/pin_edge_sync.sv ***
`timescale 1ns/1ps
module pin_edge_sync (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic pin_in,
    pin_edge_if.drv   edges
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // Two-stage synchroniser, then one history stage
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Edge pulses from the synchronised level only
    assign edges.rise = sync_ff & ~prev_ff;
    assign edges.fall = ~sync_ff & prev_ff;
endmodule
